/* hdl/lcap_pkg.sv */
// constants for the link status / device capabilities 2 register bank
// assumes a 100 MHz system clock and word-aligned Wishbone access
package lcap_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned ADR_W         = 8;
    localparam int unsigned DAT_W         = 32;
    localparam int unsigned IDX_W         = 6;
    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_LINK_STAT = 6'h12;
    localparam logic [5:0]  IDX_DEV_CAP2  = 6'h24;
    localparam logic [5:0]  IDX_DEV_CTL2  = 6'h28;
    localparam logic [5:0]  IDX_EVENTS    = 6'h30;
    // link status fields
    localparam int unsigned SLOT_CLK_BIT  = 12;
    localparam int unsigned WIDTH_LSB     = 4;
    localparam int unsigned WIDTH_W       = 6;
    localparam int unsigned SPEED_LSB     = 0;
    localparam int unsigned SPEED_W       = 4;
    // device capabilities 2 fields
    localparam int unsigned MAX_PFX_LSB   = 22;
    localparam int unsigned PFX_SUP_BIT   = 21;
    localparam int unsigned EXT_FMT_BIT   = 20;
    localparam int unsigned FLUSH_LSB     = 18;
    localparam int unsigned HINT_LSB      = 12;
    localparam int unsigned LAT_TOL_BIT   = 11;
    localparam int unsigned RO_PASS_BIT   = 10;
    localparam int unsigned WIDE_CAS_BIT  = 9;
    localparam int unsigned ATOM64_BIT    = 8;
    localparam int unsigned ATOM32_BIT    = 7;
    localparam int unsigned ATOM_RT_BIT   = 6;
    localparam int unsigned ALT_FWD_BIT   = 5;
    localparam int unsigned TMO_SUP_BIT   = 4;
    localparam int unsigned RANGES_LSB    = 0;
    localparam logic [1:0]  HINT_RSVD     = 2'h2;
    localparam logic [1:0]  HINT_NONE     = 2'h0;
    localparam logic [3:0]  RANGES_VAL    = 4'h0;
    // device control 2 and event fields
    localparam int unsigned TMO_DIS_BIT   = 4;
    localparam int unsigned EV_TMO_BIT    = 0;
    localparam int unsigned EV_MAL_BIT    = 1;
    // reset values and the outstanding count ceiling
    localparam logic [5:0]  WIDTH_RST     = 6'h00;
    localparam logic [3:0]  SPEED_RST     = 4'h0;
    localparam logic        TMO_DIS_RST   = 1'b0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
    localparam logic [3:0]  OUTST_RST     = 4'h0;
    localparam logic [3:0]  OUTST_MAX     = 4'hF;
    // completion timeout
    localparam int unsigned CPL_TMO_MS    = 50;
    localparam logic [31:0] CPL_TMO_CYC   = 32'(CPL_TMO_MS * (CLK_HZ / 1000));
endpackage

/* hdl/tlp_prefix_checker.sv */
// flags a received TLP that carries more end-end prefixes than allowed
// assumes TLP strobes come from logic on the same clock
`timescale 1ns/10ps
module tlp_prefix_checker (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tlp_valid,
    input  wire logic [2:0] i_prefix_count,
    input  wire logic       i_prefix_support,
    input  wire logic [1:0] i_max_prefixes,
    output logic            o_malformed
);
    typedef struct packed {
        logic malformed;
    } chk_t;
    chk_t q, d;
    logic [2:0] allowed;

    // no prefix support means none allowed
    assign allowed = i_prefix_support ? {1'b0, i_max_prefixes} : 3'h0;

    always_comb begin
        d = q;
        // RULE_04 too many prefixes
        d.malformed = i_tlp_valid && (i_prefix_count > allowed);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) q <= '{malformed: 1'b0};
        else q <= d;
    end
    assign o_malformed = q.malformed;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_PFX_OVER: assert property (i_tlp_valid && i_prefix_count > allowed |=> o_malformed) // RULE_04
        else $error("excess prefixes not flagged");
    AST_PFX_OK: assert property (!(i_tlp_valid && i_prefix_count > allowed) |=> !o_malformed) // RULE_04
        else $error("malformed flagged without cause");
endmodule

/* hdl/cpl_timeout_tracker.sv */
// completion timeout for outstanding non-posted requests
// assumes one-cycle issue/completion strobes on the same clock
`timescale 1ns/10ps
module cpl_timeout_tracker #(
    parameter logic [31:0] LIMIT = lcap_pkg::CPL_TMO_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_req_issue,
    input  wire logic       i_cpl_recv,
    input  wire logic       i_disable,
    output logic            o_timeout,
    output logic [3:0]      o_outstanding
);
    import lcap_pkg::*;
    typedef struct packed {
        logic [3:0]  outst;
        logic [31:0] timer;
        logic        expired;
    } trk_t;
    trk_t q, d;

    always_comb begin
        d = q;
        d.expired = 1'b0;
        if (i_req_issue && !i_cpl_recv && q.outst != OUTST_MAX) d.outst = q.outst + 4'h1;
        if (i_cpl_recv && !i_req_issue && q.outst != OUTST_RST) d.outst = q.outst - 4'h1;
        // any traffic restarts the window
        if (i_req_issue || i_cpl_recv) begin
            d.timer = 32'h0000_0000;
        // RULE_16 disable holds the timer at zero
        end else if (q.outst == OUTST_RST || i_disable) begin
            d.timer = 32'h0000_0000;
        end else if (q.timer >= LIMIT - 32'h0000_0001) begin
            d.expired = 1'b1;
            d.outst   = OUTST_RST;
            d.timer   = 32'h0000_0000;
        end else begin
            d.timer = q.timer + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) q <= '{outst: OUTST_RST, timer: 32'h0000_0000, expired: 1'b0};
        else q <= d;
    end
    assign o_timeout     = q.expired;
    assign o_outstanding = q.outst;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_TMO_DISABLED: assert property (i_disable |=> !o_timeout) // RULE_16
        else $error("timeout fired while disabled");
    AST_TMO_CAUSE: assert property (o_timeout |-> $past(q.outst) != OUTST_RST && o_outstanding == OUTST_RST) // RULE_16
        else $error("timeout without outstanding request");
endmodule

/* hdl/link_caps_regs.sv */
// link status and device capabilities 2 registers behind a Wishbone slave,
// plus the completion timeout control they steer
// assumes a classic Wishbone master and link/TLP strobes on I_CLK_SYS
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01: slot clock bit is 1 on connector reference clock, 0 on own clock.
// RULE_02: width field shows negotiated link width; meaningless while link is down.
// RULE_03: speed field shows negotiated link speed; meaningless while link is down.
// RULE_04: received TLPs with more prefixes than the maximum are malformed.
// RULE_05: prefix support bit is 1 only when prefixed TLPs are accepted.
// RULE_06: extended format bit is 1 for three-bit format decoding, else 0.
// RULE_07: buffer flush/fill field gives the fixed supported level.
// RULE_08: hint completer field uses 00, 01, 11; code 10 never appears.
// RULE_09: latency tolerance bit is 1 when that mechanism exists.
// RULE_10: relaxed passing, atomic routing and alternate forwarding bits read 0.
// RULE_11: wide compare-and-swap completer bit is 1 when supported.
// RULE_12: 64-bit atomic completer bit is 1 when supported.
// RULE_13: 32-bit atomic completer bit is 1 when supported.
// RULE_14: timeout disable support bit is always 1.
// RULE_15: timeout ranges field reports supported programmable ranges.
// RULE_16: setting timeout disable control stops timing outstanding requests.
// RULE_17: reserved bits read 0; writes to them and read-only fields do nothing.
module link_caps_regs #(
    parameter logic        SLOT_CLOCK_FROM_CONN = 1'b1,
    parameter logic [1:0]  MAX_END_END_PREFIXES = 2'h1,
    parameter logic        END_END_PREFIX_SUP   = 1'b1,
    parameter logic        EXTENDED_FORMAT_SUP  = 1'b1,
    parameter logic [1:0]  FLUSH_FILL_SUPPORT   = 2'h0,
    parameter logic [1:0]  HINT_COMPLETER       = 2'h0,
    parameter logic        LATENCY_TOL_SUPPORT  = 1'b0,
    parameter logic        WIDE_CAS_COMPLETER   = 1'b0,
    parameter logic        ATOMIC64_COMPLETER   = 1'b0,
    parameter logic        ATOMIC32_COMPLETER   = 1'b0,
    parameter logic [31:0] CPL_TIMEOUT_CYCLES   = lcap_pkg::CPL_TMO_CYC
) (
    input  wire logic                        I_CLK_SYS,
    input  wire logic                        I_RST_N,
    input  wire logic                        I_WB_CYC,
    input  wire logic                        I_WB_STB,
    input  wire logic                        I_WB_WE,
    input  wire logic [lcap_pkg::ADR_W-1:0]  I_WB_ADR,
    input  wire logic [3:0]                  I_WB_SEL,
    input  wire logic [lcap_pkg::DAT_W-1:0]  I_WB_DAT,
    output logic      [lcap_pkg::DAT_W-1:0]  O_WB_DAT,
    output logic                             O_WB_ACK,
    input  wire logic                        I_LINK_UP,
    input  wire logic [lcap_pkg::WIDTH_W-1:0] I_LINK_WIDTH,
    input  wire logic [lcap_pkg::SPEED_W-1:0] I_LINK_SPEED,
    input  wire logic                        I_TLP_VALID,
    input  wire logic [2:0]                  I_TLP_PREFIX_COUNT,
    output logic                             O_TLP_MALFORMED,
    input  wire logic                        I_REQ_ISSUE,
    input  wire logic                        I_CPL_RECV,
    output logic                             O_CPL_TIMEOUT,
    output logic      [3:0]                  O_OUTSTANDING
);
    import lcap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic                ack;
        logic [DAT_W-1:0]    rdata;
        logic [WIDTH_W-1:0]  width;
        logic [SPEED_W-1:0]  speed;
        logic                tmo_dis;
        logic                ev_tmo;
        logic                ev_mal;
    } state_t;

    state_t           q;
    state_t           d;
    logic             req;
    logic [IDX_W-1:0] idx;
    logic             wr_lane0;
    logic [DAT_W-1:0] cap2_word;
    logic [DAT_W-1:0] ls_word;
    logic [DAT_W-1:0] ctl2_word;
    logic [DAT_W-1:0] ev_word;
    logic [DAT_W-1:0] rd;
    logic             tmo_pulse;
    logic             mal_pulse;

    // reserved hint code is never reported, fall back to none
    localparam logic [1:0] HINT_EFF = (HINT_COMPLETER == HINT_RSVD) ? HINT_NONE : HINT_COMPLETER;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode; request masked while ack is high so each access answers once
    assign req      = I_WB_CYC && I_WB_STB && !q.ack;
    assign idx      = I_WB_ADR[ADR_W-1:2];
    assign wr_lane0 = req && I_WB_WE && I_WB_SEL[0];

    ////////////////////////////////////////////////////////////////////////////
    // read words, everything not assigned stays zero
    always_comb begin
        ls_word = 32'h0000_0000;
        // RULE_01 slot clock arrangement
        ls_word[SLOT_CLK_BIT] = SLOT_CLOCK_FROM_CONN;
        // RULE_02 negotiated width
        ls_word[WIDTH_LSB +: WIDTH_W] = q.width;
        // RULE_03 negotiated speed
        ls_word[SPEED_LSB +: SPEED_W] = q.speed;
    end

    always_comb begin
        cap2_word = 32'h0000_0000;
        // RULE_04 prefix limit
        cap2_word[MAX_PFX_LSB +: 2] = MAX_END_END_PREFIXES;
        // RULE_05 prefix acceptance
        cap2_word[PFX_SUP_BIT] = END_END_PREFIX_SUP;
        // RULE_06 format width
        cap2_word[EXT_FMT_BIT] = EXTENDED_FORMAT_SUP;
        // RULE_07 flush/fill level
        cap2_word[FLUSH_LSB +: 2] = FLUSH_FILL_SUPPORT;
        // RULE_08 hint completer code
        cap2_word[HINT_LSB +: 2] = HINT_EFF;
        // RULE_09 latency tolerance
        cap2_word[LAT_TOL_BIT] = LATENCY_TOL_SUPPORT;
        // RULE_10 inapplicable bits zero
        cap2_word[RO_PASS_BIT] = 1'b0;
        cap2_word[ATOM_RT_BIT] = 1'b0;
        cap2_word[ALT_FWD_BIT] = 1'b0;
        // RULE_11 wide compare-and-swap
        cap2_word[WIDE_CAS_BIT] = WIDE_CAS_COMPLETER;
        // RULE_12 64-bit atomics
        cap2_word[ATOM64_BIT] = ATOMIC64_COMPLETER;
        // RULE_13 32-bit atomics
        cap2_word[ATOM32_BIT] = ATOMIC32_COMPLETER;
        // RULE_14 disable always supported
        cap2_word[TMO_SUP_BIT] = 1'b1;
        // RULE_15 timeout ranges; the timeout is not programmable
        cap2_word[RANGES_LSB +: 4] = RANGES_VAL;
    end

    always_comb begin
        ctl2_word = 32'h0000_0000;
        ctl2_word[TMO_DIS_BIT] = q.tmo_dis;
        ev_word = 32'h0000_0000;
        ev_word[EV_TMO_BIT] = q.ev_tmo;
        ev_word[EV_MAL_BIT] = q.ev_mal;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d  = q;
        rd = 32'h0000_0000;
        // RULE_17 unmapped and reserved read zero
        case (idx)
            IDX_LINK_STAT: rd = ls_word;
            IDX_DEV_CAP2:  rd = cap2_word;
            IDX_DEV_CTL2:  rd = ctl2_word;
            IDX_EVENTS:    rd = ev_word;
            default:       rd = 32'h0000_0000;
        endcase
        d.ack = req;
        if (req) d.rdata = rd;

        // RULE_02 capture width while up
        // values are held while down; software must not trust them then
        if (I_LINK_UP) begin
            d.width = I_LINK_WIDTH;
            // RULE_03 capture speed while up
            d.speed = I_LINK_SPEED;
        end

        // RULE_16 software sets disable control
        // RULE_17 only this bit of control is writable
        if (wr_lane0 && idx == IDX_DEV_CTL2) d.tmo_dis = I_WB_DAT[TMO_DIS_BIT];

        // write one to clear; a same-cycle event wins over the clear
        if (wr_lane0 && idx == IDX_EVENTS) begin
            d.ev_tmo = q.ev_tmo && !I_WB_DAT[EV_TMO_BIT];
            d.ev_mal = q.ev_mal && !I_WB_DAT[EV_MAL_BIT];
        end
        if (tmo_pulse) d.ev_tmo = 1'b1;
        if (mal_pulse) d.ev_mal = 1'b1;
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            q <= '{ack: 1'b0, rdata: RDATA_RST, width: WIDTH_RST, speed: SPEED_RST,
                   tmo_dis: TMO_DIS_RST, ev_tmo: 1'b0, ev_mal: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign O_WB_ACK = q.ack;
    assign O_WB_DAT = q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    tlp_prefix_checker u_prefix (
        .i_clk            (I_CLK_SYS),
        .i_rst_n          (I_RST_N),
        .i_tlp_valid      (I_TLP_VALID),
        .i_prefix_count   (I_TLP_PREFIX_COUNT),
        .i_prefix_support (END_END_PREFIX_SUP),
        .i_max_prefixes   (MAX_END_END_PREFIXES),
        .o_malformed      (mal_pulse)
    );

    // RULE_16 control bit gates the timer
    cpl_timeout_tracker #(
        .LIMIT (CPL_TIMEOUT_CYCLES)
    ) u_timeout (
        .i_clk         (I_CLK_SYS),
        .i_rst_n       (I_RST_N),
        .i_req_issue   (I_REQ_ISSUE),
        .i_cpl_recv    (I_CPL_RECV),
        .i_disable     (q.tmo_dis),
        .o_timeout     (tmo_pulse),
        .o_outstanding (O_OUTSTANDING)
    );

    assign O_TLP_MALFORMED = mal_pulse;
    assign O_CPL_TIMEOUT   = tmo_pulse;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);

    sequence s_read(logic [5:0] r);
        I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK && idx == r;
    endsequence
    sequence s_write(logic [5:0] r);
        I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0] && !O_WB_ACK && idx == r;
    endsequence

    AST_ACK_ONCE: assert property (req |=> O_WB_ACK ##1 !O_WB_ACK) // RULE_17
        else $error("ack not a single pulse after request");
    AST_LS_READ: assert property (s_read(IDX_LINK_STAT) |=> O_WB_ACK && O_WB_DAT[12] == SLOT_CLOCK_FROM_CONN
                                  && O_WB_DAT[15:13] == 3'h0 && O_WB_DAT[11:10] == 2'h0) // RULE_01
        else $error("link status read wrong");
    AST_LINK_CAPTURE: assert property (I_LINK_UP |=> q.width == $past(I_LINK_WIDTH)
                                       && q.speed == $past(I_LINK_SPEED)) // RULE_02
        else $error("negotiated link values not captured");
    AST_LINK_READ: assert property (s_read(IDX_LINK_STAT) |=> O_WB_DAT[9:4] == $past(q.width)
                                    && O_WB_DAT[3:0] == $past(q.speed)) // RULE_03
        else $error("link width or speed read wrong");
    AST_CAP2_FIXED: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[4] == 1'b1 && O_WB_DAT[31:24] == 8'h00
                                     && O_WB_DAT[17:14] == 4'h0) // RULE_14
        else $error("capabilities 2 fixed bits wrong");
    AST_CAP2_ZERO: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[10] == 1'b0 && O_WB_DAT[6] == 1'b0
                                    && O_WB_DAT[5] == 1'b0) // RULE_10
        else $error("inapplicable capability bit set");
    AST_HINT_CODE: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[13:12] != HINT_RSVD) // RULE_08
        else $error("reserved hint completer code reported");
    AST_PFX_FIELD: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[23:22] == MAX_END_END_PREFIXES
                                    && O_WB_DAT[21] == END_END_PREFIX_SUP) // RULE_05
        else $error("prefix capability fields wrong");
    AST_CTL_WRITE: assert property (s_write(IDX_DEV_CTL2) |=> q.tmo_dis == $past(I_WB_DAT[4])) // RULE_16
        else $error("timeout disable control not written");
    AST_RO_WRITE: assert property (s_write(IDX_DEV_CAP2) |=> $stable(q.tmo_dis)) // RULE_17
        else $error("write to read-only register changed state");
    AST_UNMAPPED: assert property (s_read(6'h00) |=> O_WB_DAT == 32'h0000_0000) // RULE_17
        else $error("unmapped read not zero");
    AST_EV_SET_WINS: assert property (tmo_pulse |=> q.ev_tmo) // RULE_16
        else $error("timeout event lost");

    ////////////////////////////////////////////////////////////////////////////
    // field checks; any legal parameter set must still give these words
    sequence s_sel_off;
        I_WB_CYC && I_WB_STB && I_WB_WE && !I_WB_SEL[0] && !O_WB_ACK;
    endsequence

    AST_CAP2_FORMAT: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[20] == EXTENDED_FORMAT_SUP // RULE_06
                                      && O_WB_DAT[19:18] == FLUSH_FILL_SUPPORT)
        else $error("format or flush/fill field wrong");
    AST_CAP2_LAT_TOL: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[11] == LATENCY_TOL_SUPPORT) // RULE_09
        else $error("latency tolerance bit wrong");
    AST_CAP2_ATOMICS: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[9] == WIDE_CAS_COMPLETER // RULE_12
                                       && O_WB_DAT[8] == ATOMIC64_COMPLETER && O_WB_DAT[7] == ATOMIC32_COMPLETER)
        else $error("atomic completer bits wrong");
    AST_CAP2_RANGES: assert property (s_read(IDX_DEV_CAP2) |=> O_WB_DAT[3:0] == RANGES_VAL) // RULE_15
        else $error("timeout ranges field wrong");
    AST_LS_UPPER: assert property (s_read(IDX_LINK_STAT) |=> O_WB_DAT[31:16] == 16'h0000) // RULE_17
        else $error("link status upper half not zero");
    AST_CTL_READ: assert property (s_read(IDX_DEV_CTL2) |=> O_WB_DAT[4] == $past(q.tmo_dis) // RULE_16
                                   && O_WB_DAT[31:5] == 27'h0000000 && O_WB_DAT[3:0] == 4'h0)
        else $error("device control 2 read wrong");
    AST_EV_READ: assert property (s_read(IDX_EVENTS) |=> O_WB_DAT[31:2] == 30'h0000_0000) // RULE_17
        else $error("event register reserved bits set");

    // bus and event behaviour
    AST_SEL_GUARD: assert property (s_sel_off |=> $stable(q.tmo_dis)) // RULE_17
        else $error("write without lane 0 changed control");
    AST_ACK_IDLE: assert property (!req |=> !O_WB_ACK) // RULE_17
        else $error("ack without a taken request");
    AST_DATA_HOLD: assert property (!req |=> $stable(O_WB_DAT)) // RULE_17
        else $error("read data changed between accesses");
    // held values may be stale; software must look at link up first
    AST_LINK_HOLD: assert property (!I_LINK_UP |=> $stable(q.width) && $stable(q.speed)) // RULE_02
        else $error("link values changed while link down");
    AST_EV_MAL_SET: assert property (mal_pulse |=> q.ev_mal) // RULE_04
        else $error("malformed event lost");
    AST_EV_CLEAR: assert property (s_write(IDX_EVENTS) ##0 (I_WB_DAT[0] && !tmo_pulse) |=> !q.ev_tmo) // RULE_17
        else $error("timeout event not cleared");
    AST_DIS_QUIET: assert property (q.tmo_dis |=> !O_CPL_TIMEOUT) // RULE_16
        else $error("timeout pulse while disabled");
    AST_TMO_CLEARS: assert property (O_CPL_TIMEOUT |-> O_OUTSTANDING == 4'h0) // RULE_16
        else $error("outstanding count kept after timeout");
endmodule

/* sim/link_caps_regs_test.sv */
// self-checking bench for the link status / capabilities 2 register bank
// assumes the design files and lcap_pkg are compiled first; one 100 MHz clock
`timescale 1ns/10ps
module link_caps_regs_test;
    import lcap_pkg::*;

    localparam logic        SLOT_CLK = 1'b1;
    localparam logic [1:0]  MAX_PFX  = 2'h1;
    localparam logic        PFX_SUP  = 1'b1;
    localparam logic        EXT_FMT  = 1'b1;
    // short limit keeps the timeout scenarios to a few dozen cycles
    localparam logic [31:0] TMO_LIM  = 32'h0000_0008;
    localparam int          CEILING  = 4000;

    logic              clk_sys, rst_n, wb_cyc, wb_stb, wb_we;
    logic [ADR_W-1:0]  wb_adr;
    logic [3:0]        wb_sel;
    logic [DAT_W-1:0]  wb_wdat, wb_rdat, rd;
    logic              wb_ack, link_up, tlp_valid, tlp_bad, req_issue, cpl_recv, cpl_tmo;
    logic [WIDTH_W-1:0] link_width;
    logic [SPEED_W-1:0] link_speed;
    logic [2:0]        pfx_cnt;
    logic [3:0]        outst;
    int                fails, n_checks, cycles, n;
    logic [31:0]       exp_cap2;

    link_caps_regs #(
        .SLOT_CLOCK_FROM_CONN (SLOT_CLK),
        .MAX_END_END_PREFIXES (MAX_PFX),
        .END_END_PREFIX_SUP   (PFX_SUP),
        .EXTENDED_FORMAT_SUP  (EXT_FMT),
        .CPL_TIMEOUT_CYCLES   (TMO_LIM)
    ) i_link_caps_regs (
        .I_CLK_SYS          (clk_sys),
        .I_RST_N            (rst_n),
        .I_WB_CYC           (wb_cyc),
        .I_WB_STB           (wb_stb),
        .I_WB_WE            (wb_we),
        .I_WB_ADR           (wb_adr),
        .I_WB_SEL           (wb_sel),
        .I_WB_DAT           (wb_wdat),
        .O_WB_DAT           (wb_rdat),
        .O_WB_ACK           (wb_ack),
        .I_LINK_UP          (link_up),
        .I_LINK_WIDTH       (link_width),
        .I_LINK_SPEED       (link_speed),
        .I_TLP_VALID        (tlp_valid),
        .I_TLP_PREFIX_COUNT (pfx_cnt),
        .O_TLP_MALFORMED    (tlp_bad),
        .I_REQ_ISSUE        (req_issue),
        .I_CPL_RECV         (cpl_recv),
        .O_CPL_TIMEOUT      (cpl_tmo),
        .O_OUTSTANDING      (outst)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; data taken at the edge that samples ack high
    task automatic wb_io(input logic we, input logic [5:0] idx, input logic [3:0] sel,
                         input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_sys);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= {idx, 2'b00};
        wb_sel  <= sel;
        wb_wdat <= wdat;
        // ack read in the edge's own step is its sampled value; only the ceiling ends a hang
        do begin
            @(posedge clk_sys);
        end while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        wb_io(1'b0, idx, 4'hF, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    task automatic pulse_req(input logic issue, input logic cpl);
        @(posedge clk_sys);
        req_issue <= issue;
        cpl_recv  <= cpl;
        @(posedge clk_sys);
        req_issue <= 1'b0;
        cpl_recv  <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {wb_cyc, wb_stb, wb_we, link_up, tlp_valid, req_issue, cpl_recv} = 7'h00;
        wb_adr = 8'h00; wb_sel = 4'h0; wb_wdat = 32'h0000_0000;
        link_width = 6'h00; link_speed = 4'h0; pfx_cnt = 3'h0;
        fails = 0; n_checks = 0; cycles = 0; rst_n = 1'b0;
        exp_cap2 = (32'(MAX_PFX) << MAX_PFX_LSB) | (32'(PFX_SUP) << PFX_SUP_BIT)
                 | (32'(EXT_FMT) << EXT_FMT_BIT) | (32'h1 << TMO_SUP_BIT);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);

        rd_chk(IDX_LINK_STAT, 32'(SLOT_CLK) << SLOT_CLK_BIT);
        @(posedge clk_sys);
        link_up <= 1'b1; link_width <= 6'h10; link_speed <= 4'h3;
        @(posedge clk_sys);
        link_up <= 1'b0; link_width <= 6'h3F; link_speed <= 4'hF;
        rd_chk(IDX_LINK_STAT, 32'h0000_1103);
        wb_io(1'b1, IDX_LINK_STAT, 4'hF, 32'hFFFF_FFFF, rd);
        rd_chk(IDX_LINK_STAT, 32'h0000_1103);
        $display("test link status done");

        rd_chk(IDX_DEV_CAP2, exp_cap2);
        chk(rd & 32'h0000_3F8F, 32'h0000_0000);
        wb_io(1'b1, IDX_DEV_CAP2, 4'hF, 32'hFFFF_FFFF, rd);
        rd_chk(IDX_DEV_CAP2, exp_cap2);
        rd_chk(6'h00, 32'h0000_0000);
        $display("test capabilities done");

        // every prefix count, legal and excessive
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_sys);
            tlp_valid <= 1'b1;
            pfx_cnt   <= 3'(c);
            @(posedge clk_sys);
            tlp_valid <= 1'b0;
            #1;
            chk({31'h0, tlp_bad}, {31'h0, (c > int'(MAX_PFX))});
        end
        rd_chk(IDX_EVENTS, 32'h0000_0002);
        wb_io(1'b1, IDX_EVENTS, 4'hF, 32'h0000_0003, rd);
        rd_chk(IDX_EVENTS, 32'h0000_0000);
        $display("test prefix check done");

        pulse_req(1'b1, 1'b0);
        chk({28'h0, outst}, 32'h0000_0001);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end while (cpl_tmo !== 1'b1 && n < 40);
        chk(32'(n), TMO_LIM);
        chk({28'h0, outst}, 32'h0000_0000);
        @(posedge clk_sys);
        #1;
        chk({31'h0, cpl_tmo}, 32'h0000_0000);
        rd_chk(IDX_EVENTS, 32'h0000_0001);
        wb_io(1'b1, IDX_EVENTS, 4'hF, 32'h0000_0001, rd);
        $display("test timeout done");

        wb_io(1'b1, IDX_DEV_CTL2, 4'hF, 32'h0000_0010, rd);
        rd_chk(IDX_DEV_CTL2, 32'h0000_0010);
        wb_io(1'b1, IDX_DEV_CTL2, 4'hE, 32'h0000_0000, rd);
        rd_chk(IDX_DEV_CTL2, 32'h0000_0010);
        pulse_req(1'b1, 1'b0);
        n = 0;
        repeat (3 * int'(TMO_LIM)) begin
            @(posedge clk_sys);
            #1;
            if (cpl_tmo !== 1'b0) n = n + 1;
        end
        chk(32'(n), 32'h0000_0000);
        chk({28'h0, outst}, 32'h0000_0001);
        pulse_req(1'b1, 1'b1);
        chk({28'h0, outst}, 32'h0000_0001);
        pulse_req(1'b0, 1'b1);
        chk({28'h0, outst}, 32'h0000_0000);
        rd_chk(IDX_EVENTS, 32'h0000_0000);
        $display("test timeout disable done");
        finish_test();
    end
endmodule
